// ### pkg/icma_pkg.sv
// Shared constants and types for the configuration memory access link.
package icma_pkg;
    // System clock and link timing.
    localparam int CLK_MHZ = 100;
    localparam int SCL_KHZ = 100;
    localparam int SCL_QTR_CYCLES = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
    localparam int PROG_TIME_US = 5;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

    // Pointer map.
    localparam logic [7:0] CFG_FIRST = 8'h00;
    localparam logic [7:0] CFG_LAST = 8'h9F;
    localparam logic [7:0] GP0_FIRST = 8'hA0;
    localparam logic [7:0] GP0_LAST = 8'hBF;
    localparam logic [7:0] GP1_FIRST = 8'hC0;
    localparam logic [7:0] GP1_LAST = 8'hFF;

    // Lock register inside the configuration space.
    localparam logic [7:0] LOCK_REG = 8'h9F;
    localparam int LOCK_GP0_BIT = 0;
    localparam int LOCK_GP1_BIT = 1;
    localparam logic [7:0] MEM_RESET = 8'h00;

    // Page layout: one first byte plus up to fifteen more.
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_EXTRA = 15;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [3:0] LAST_SLOT = 4'h8;

    typedef enum logic [8:0] {
        D_IDLE = 9'h001,
        D_ADDR = 9'h002,
        D_ACK_A = 9'h004,
        D_PTR = 9'h008,
        D_ACK_P = 9'h010,
        D_WR = 9'h020,
        D_ACK_W = 9'h040,
        D_RD = 9'h080,
        D_ACK_R = 9'h100
    } icma_dev_state_t;

    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_START = 4'h2,
        H_BIT = 4'h4,
        H_STOP = 4'h8
    } icma_host_state_t;

    typedef enum logic [4:0] {
        STEP_ADDR_W = 5'h01,
        STEP_PTR = 5'h02,
        STEP_WDATA = 5'h04,
        STEP_ADDR_R = 5'h08,
        STEP_RDATA = 5'h10
    } icma_step_t;
endpackage : icma_pkg

// ### pkg/icma_if.sv
// Two-wire link between the bus host and the configuration memory device.
`timescale 1ns/1ps
`default_nettype none
interface icma_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    wire logic sda;

    // The line is pulled up and any enabled low driver pulls it down.
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (
        output scl,
        output host_sda_o,
        output host_sda_oe,
        input sda
    );

    modport device (
        input scl,
        output dev_sda_o,
        output dev_sda_oe,
        input sda
    );
endinterface : icma_if
`default_nettype wire

// ### verilog/icma_device.sv
// Configuration memory device end: two-wire slave, page buffer and commit.
// Operation
// - Start plus matching write address is acknowledged while not programming
// - Pointer byte loads pointer, acknowledged, data follows
// - Page write takes up to fifteen more
// - Stop after data starts nonvolatile programming
// - Host sets pointer by dummy write first
// - Repeated start, read address, acknowledge, data out
// - First read byte comes from loaded pointer
// - Host acknowledge advances pointer to next byte
// - Host no-acknowledge then stop ends read
// - Pointers 00 to 9F are configuration
// - Pointers A0 to BF are block zero
// - Pointers C0 to FF are block one
// - Each block locks through its own bit
// - One programmable address selects every region
// - MSB first, sample rising, drive falling
`timescale 1ns/1ps
`default_nettype none
module icma_device #(
    parameter int PROG_CYCLES = icma_pkg::PROG_CYCLES
) (
    // System side
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [6:0] slave_addr,
    output logic nv_busy,
    output logic [1:0] gp_locked,
    // Link side
    icma_if.device link
);
    // Nonvolatile array, system domain.
    logic [7:0] nv_mem [0:255];
    // Page buffer, link domain.
    logic [7:0] page_data [0:icma_pkg::PAGE_BYTES-1];
    logic [icma_pkg::PAGE_BYTES-1:0] page_valid;
    logic [3:0] page_hi;

    icma_pkg::icma_dev_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [7:0] tx;
    logic rw;
    logic sda_rise;
    logic sda_oe;
    logic start_tgl;
    logic stop_tgl;
    logic start_seen;
    logic busy_s1;
    logic busy_s2;
    logic [6:0] addr_s1;
    logic [6:0] addr_s2;
    logic stop_s1;
    logic stop_s2;
    logic stop_s3;
    logic [31:0] prog_cnt;

    // Start and stop are seen as data edges while the clock is high.
    always_ff @(negedge link.sda or posedge sys_rst)
    begin
        if (sys_rst)
            start_tgl <= 1'h0;
        else if (link.scl)
            start_tgl <= ~start_tgl;
    end

    always_ff @(posedge link.sda or posedge sys_rst)
    begin
        if (sys_rst)
            stop_tgl <= 1'h0;
        else if (link.scl)
            stop_tgl <= ~stop_tgl;
    end

    // Incoming bits are taken on the rising clock edge.
    always_ff @(posedge link.scl or posedge sys_rst)
    begin
        if (sys_rst)
            sda_rise <= 1'h0;
        else
            sda_rise <= link.sda;
    end

    // Busy flag and slave address enter the link domain through two stages.
    always_ff @(negedge link.scl or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busy_s1 <= 1'h0;
            busy_s2 <= 1'h0;
            addr_s1 <= 7'h00;
            addr_s2 <= 7'h00;
        end
        else
        begin
            busy_s1 <= nv_busy;
            busy_s2 <= busy_s1;
            addr_s1 <= slave_addr;
            addr_s2 <= addr_s1;
        end
    end

    wire logic start_now = start_tgl != start_seen;
    wire logic [7:0] rx_byte = {shreg[6:0], sda_rise};
    wire logic byte_done = bit_cnt == icma_pkg::LAST_BIT;
    wire logic addr_match = rx_byte[7:1] == addr_s2;
    wire logic addr_hit = addr_match & ~busy_s2;
    wire logic [7:0] next_ptr = ptr + 8'h01;
    wire logic [7:0] rd_byte = nv_mem[ptr];
    wire logic [7:0] rd_next = nv_mem[next_ptr];
    wire logic host_ack = ~sda_rise;

    // Byte engine; all output changes happen on the falling clock edge.
    always_ff @(negedge link.scl or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= icma_pkg::D_IDLE;
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            tx <= 8'h00;
            rw <= 1'h0;
            sda_oe <= 1'h0;
            start_seen <= 1'h0;
            page_valid <= '0;
            page_hi <= 4'h0;
        end
        else if (start_now)
        begin
            start_seen <= start_tgl;
            state <= icma_pkg::D_ADDR;
            bit_cnt <= 3'h0;
            sda_oe <= 1'h0;
            page_valid <= '0;
        end
        else
        begin
            shreg <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
            unique case (state)
                icma_pkg::D_IDLE:
                    bit_cnt <= 3'h0;
                icma_pkg::D_ADDR:
                    if (byte_done)
                    begin
                        if (addr_hit)
                        begin
                            rw <= sda_rise;
                            sda_oe <= 1'h1;
                            state <= icma_pkg::D_ACK_A;
                        end
                        else
                            state <= icma_pkg::D_IDLE;
                    end
                icma_pkg::D_ACK_A:
                begin
                    bit_cnt <= 3'h0;
                    if (rw)
                    begin
                        tx <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                        state <= icma_pkg::D_RD;
                    end
                    else
                    begin
                        sda_oe <= 1'h0;
                        state <= icma_pkg::D_PTR;
                    end
                end
                icma_pkg::D_PTR:
                    if (byte_done)
                    begin
                        ptr <= rx_byte;
                        page_hi <= rx_byte[7:4];
                        sda_oe <= 1'h1;
                        state <= icma_pkg::D_ACK_P;
                    end
                icma_pkg::D_ACK_P, icma_pkg::D_ACK_W:
                begin
                    bit_cnt <= 3'h0;
                    sda_oe <= 1'h0;
                    state <= icma_pkg::D_WR;
                end
                icma_pkg::D_WR:
                    if (byte_done)
                    begin
                        page_valid[ptr[3:0]] <= 1'h1;
                        ptr <= {ptr[7:4], ptr[3:0] + 4'h1};
                        sda_oe <= 1'h1;
                        state <= icma_pkg::D_ACK_W;
                    end
                icma_pkg::D_RD:
                    if (byte_done)
                    begin
                        sda_oe <= 1'h0;
                        state <= icma_pkg::D_ACK_R;
                    end
                    else
                    begin
                        tx <= {tx[6:0], 1'h0};
                        sda_oe <= ~tx[6];
                    end
                icma_pkg::D_ACK_R:
                begin
                    bit_cnt <= 3'h0;
                    if (host_ack)
                    begin
                        ptr <= next_ptr;
                        tx <= rd_next;
                        sda_oe <= ~rd_next[7];
                        state <= icma_pkg::D_RD;
                    end
                    else
                        state <= icma_pkg::D_IDLE;
                end
            endcase
        end
    end

    // Page data has no reset; page_valid says which entries hold data.
    always_ff @(negedge link.scl)
    begin
        if (state == icma_pkg::D_WR && byte_done && !start_now)
            page_data[ptr[3:0]] <= rx_byte;
    end

    assign link.dev_sda_oe = sda_oe;
    assign link.dev_sda_o = 1'h0;

    // Stop events cross into the system domain as a toggle.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stop_s1 <= 1'h0;
            stop_s2 <= 1'h0;
            stop_s3 <= 1'h0;
        end
        else
        begin
            stop_s1 <= stop_tgl;
            stop_s2 <= stop_s1;
            stop_s3 <= stop_s2;
        end
    end

    // The buffer is stable here: no new transfer can start this soon.
    wire logic commit_go = (stop_s2 ^ stop_s3) & (|page_valid) & ~nv_busy;
    wire logic lock0 = nv_mem[icma_pkg::LOCK_REG][icma_pkg::LOCK_GP0_BIT];
    wire logic lock1 = nv_mem[icma_pkg::LOCK_REG][icma_pkg::LOCK_GP1_BIT];

    function automatic logic icma_locked(input logic [7:0] a, input logic l0, input logic l1);
        logic in_gp0;
        logic in_gp1;
        in_gp0 = a >= icma_pkg::GP0_FIRST && a <= icma_pkg::GP0_LAST;
        in_gp1 = a >= icma_pkg::GP1_FIRST;
        return (in_gp0 & l0) | (in_gp1 & l1);
    endfunction : icma_locked

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            nv_busy <= 1'h0;
            prog_cnt <= 32'h0;
            gp_locked <= 2'h0;
        end
        else
        begin
            gp_locked <= {lock1, lock0};
            if (commit_go)
            begin
                nv_busy <= 1'h1;
                prog_cnt <= 32'(PROG_CYCLES - 1);
            end
            else if (nv_busy)
            begin
                if (prog_cnt == 32'h0)
                    nv_busy <= 1'h0;
                else
                    prog_cnt <= prog_cnt - 32'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 256; i++)
                nv_mem[i] <= icma_pkg::MEM_RESET;
        end
        else if (commit_go)
        begin
            for (int i = 0; i < icma_pkg::PAGE_BYTES; i++)
                if (page_valid[i] && !icma_locked({page_hi, 4'(i)}, lock0, lock1))
                    nv_mem[{page_hi, 4'(i)}] <= page_data[i];
        end
    end
endmodule : icma_device
`default_nettype wire

// ### verilog/icma_host.sv
// Bus host end: runs one write or pointer-then-read transfer per command.
`timescale 1ns/1ps
`default_nettype none
module icma_host #(
    parameter int QTR_CYCLES = icma_pkg::SCL_QTR_CYCLES
) (
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [6:0] cmd_addr,
    input wire logic [7:0] cmd_ptr,
    input wire logic [4:0] cmd_len,
    // Write data
    input wire logic [7:0] wr_data,
    output logic wr_taken,
    // Read data and completion
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic done,
    output logic nack,
    // Link
    icma_if.host link
);
    icma_pkg::icma_host_state_t state;
    icma_pkg::icma_step_t step;
    logic [15:0] div_cnt;
    logic [1:0] qtr;
    logic [3:0] slot;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [4:0] remain;
    logic rd_mode;
    logic [6:0] addr;
    logic ack_bad;
    logic scl;
    logic sda_oe;
    logic sda_s1;
    logic sda_s2;
    logic [7:0] cmd_ptr_q;

    wire logic tick = div_cnt == 16'(QTR_CYCLES - 1);
    wire logic q0 = tick && qtr == 2'h0;
    wire logic q1 = tick && qtr == 2'h1;
    wire logic q2 = tick && qtr == 2'h2;
    wire logic q3 = tick && qtr == 2'h3;
    wire logic data_slot = slot != icma_pkg::LAST_SLOT;
    wire logic rx_step = step == icma_pkg::STEP_RDATA;
    wire logic last_byte = remain == 5'h01;

    // Clock divider: four quarters make one link clock period.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div_cnt <= 16'h0;
            qtr <= 2'h0;
            sda_s1 <= 1'h1;
            sda_s2 <= 1'h1;
        end
        else
        begin
            div_cnt <= tick ? 16'h0 : div_cnt + 16'h1;
            qtr <= tick ? qtr + 2'h1 : qtr;
            sda_s1 <= link.sda;
            sda_s2 <= sda_s1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= icma_pkg::H_IDLE;
            step <= icma_pkg::STEP_ADDR_W;
            cmd_ready <= 1'h1;
            slot <= 4'h0;
            tx <= 8'h00;
            rx <= 8'h00;
            remain <= 5'h00;
            rd_mode <= 1'h0;
            addr <= 7'h00;
            ack_bad <= 1'h0;
            scl <= 1'h1;
            sda_oe <= 1'h0;
            wr_taken <= 1'h0;
            rd_valid <= 1'h0;
            rd_data <= 8'h00;
            done <= 1'h0;
            nack <= 1'h0;
        end
        else
        begin
            wr_taken <= 1'h0;
            rd_valid <= 1'h0;
            done <= 1'h0;
            unique case (state)
                icma_pkg::H_IDLE:
                    if (cmd_valid && cmd_ready)
                    begin
                        cmd_ready <= 1'h0;
                        addr <= cmd_addr;
                        rd_mode <= cmd_read;
                        remain <= cmd_len;
                        tx <= {cmd_addr, 1'h0};
                        step <= icma_pkg::STEP_ADDR_W;
                        nack <= 1'h0;
                        state <= icma_pkg::H_START;
                    end
                icma_pkg::H_START:
                begin
                    if (q0)
                        sda_oe <= 1'h0;
                    if (q1)
                        scl <= 1'h1;
                    if (q2)
                        sda_oe <= 1'h1;
                    // A command can arrive in any quarter; clocking starts only after the start.
                    if (q3 && sda_oe)
                    begin
                        scl <= 1'h0;
                        slot <= 4'h0;
                        state <= icma_pkg::H_BIT;
                    end
                end
                icma_pkg::H_BIT:
                begin
                    if (q0)
                        sda_oe <= data_slot ? (~rx_step & ~tx[7]) : (rx_step & ~last_byte);
                    if (q1)
                        scl <= 1'h1;
                    if (q2 && data_slot)
                    begin
                        rx <= {rx[6:0], sda_s2};
                        tx <= {tx[6:0], 1'h0};
                    end
                    if (q2 && !data_slot)
                        ack_bad <= sda_s2 & ~rx_step;
                    if (q3)
                    begin
                        scl <= 1'h0;
                        slot <= slot + 4'h1;
                        if (!data_slot)
                        begin
                            slot <= 4'h0;
                            if (ack_bad)
                            begin
                                nack <= 1'h1;
                                state <= icma_pkg::H_STOP;
                            end
                            else
                                unique case (step)
                                    icma_pkg::STEP_ADDR_W:
                                    begin
                                        tx <= cmd_ptr_q;
                                        step <= icma_pkg::STEP_PTR;
                                    end
                                    icma_pkg::STEP_PTR:
                                        if (rd_mode)
                                        begin
                                            tx <= {addr, 1'h1};
                                            step <= icma_pkg::STEP_ADDR_R;
                                            state <= icma_pkg::H_START;
                                        end
                                        else
                                        begin
                                            tx <= wr_data;
                                            wr_taken <= 1'h1;
                                            step <= icma_pkg::STEP_WDATA;
                                        end
                                    icma_pkg::STEP_WDATA:
                                    begin
                                        remain <= remain - 5'h01;
                                        tx <= wr_data;
                                        wr_taken <= ~last_byte;
                                        if (last_byte)
                                            state <= icma_pkg::H_STOP;
                                    end
                                    icma_pkg::STEP_ADDR_R:
                                        step <= icma_pkg::STEP_RDATA;
                                    icma_pkg::STEP_RDATA:
                                    begin
                                        rd_valid <= 1'h1;
                                        rd_data <= rx;
                                        remain <= remain - 5'h01;
                                        if (last_byte)
                                            state <= icma_pkg::H_STOP;
                                    end
                                endcase
                        end
                    end
                end
                icma_pkg::H_STOP:
                begin
                    if (q0)
                        sda_oe <= 1'h1;
                    if (q1)
                        scl <= 1'h1;
                    if (q2)
                        sda_oe <= 1'h0;
                    if (q3)
                    begin
                        done <= 1'h1;
                        cmd_ready <= 1'h1;
                        state <= icma_pkg::H_IDLE;
                    end
                end
            endcase
        end
    end

    // The pointer is held for the whole transfer.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cmd_ptr_q <= 8'h00;
        else if (state == icma_pkg::H_IDLE && cmd_valid && cmd_ready)
            cmd_ptr_q <= cmd_ptr;
    end

    assign link.scl = scl;
    assign link.host_sda_oe = sda_oe;
    assign link.host_sda_o = 1'h0;
endmodule : icma_host
`default_nettype wire

// ### verif/icma_link_monitor.sv
// Checker for the two-wire link between the host and device ends.
`timescale 1ns/1ps
`default_nettype none
module icma_link_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link wires
    input wire logic scl,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_dev_turn_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device moved sda while scl high");
    a_dev_quiet_high: assert property (scl && $past(scl) && $changed(sda) |-> !dev_sda_oe && !$past(dev_sda_oe))
        else $error("sda moved by device while scl high");
    a_no_contention: assert property (scl |-> !(dev_sda_oe && host_sda_oe))
        else $error("both ends drive sda while scl high");
    a_scl_low_bound: assert property ($fell(scl) |-> ##[1:16] scl)
        else $error("scl low phase too long");
    a_scl_high_hold: assert property ($rose(scl) |-> scl [*4])
        else $error("scl high phase too short");
    a_start_then_low: assert property (scl && $past(scl) && $fell(sda) |-> ##[1:8] !scl)
        else $error("no clock after start");
    a_stop_release: assert property (scl && $past(scl) && $rose(sda) |-> !dev_sda_oe [*8])
        else $error("device drives sda after stop");
    a_oe_bounded: assert property ($rose(dev_sda_oe) |-> ##[1:200] !dev_sda_oe)
        else $error("device holds sda too long");
endmodule : icma_link_monitor
`default_nettype wire

// ### verif/icma_bench.sv
// Self-checking bench joining the host and device ends over one link.
`timescale 1ns/1ps
`default_nettype none
module icma_bench;
    localparam logic [6:0] DEV = 7'h2C;
    logic clk, sys_rst, cmd_valid, cmd_ready, cmd_read, wr_taken, rd_valid, done, nack, nv_busy;
    logic [6:0] slave_addr, cmd_addr;
    logic [7:0] cmd_ptr, wr_data, rd_data;
    logic [4:0] cmd_len;
    logic [1:0] gp_locked;
    logic [7:0] wbuf [16];
    logic [7:0] rbuf [32];
    int rcnt, error_cnt, num_checks;

    icma_if link ();
    icma_host #(.QTR_CYCLES(4)) u_icma_host (.clk(clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
        .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .wr_data(wr_data), .wr_taken(wr_taken),
        .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack), .link(link));
    icma_device #(.PROG_CYCLES(400)) u_icma_device (.clk(clk), .sys_rst(sys_rst),
        .slave_addr(slave_addr), .nv_busy(nv_busy), .gp_locked(gp_locked), .link(link));
    icma_link_monitor u_icma_link_monitor (.clk(clk), .sys_rst(sys_rst), .scl(link.scl),
        .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One command on the host port; write bytes come from wbuf, read bytes go to rbuf.
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] p, input int n,
        input logic exp_nack);
        int wi;
        int t;
        bit fin;
        wi = 0;
        t = 0;
        fin = 0;
        rcnt = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_addr <= a;
        cmd_ptr <= p;
        cmd_len <= 5'(n);
        wr_data <= wbuf[0];
        @(posedge clk);
        cmd_valid <= 1'b0;
        while (!fin && t < 20000)
        begin
            @(negedge clk);
            wi += (wr_taken === 1'b1) ? 1 : 0;
            if (rd_valid === 1'b1)
            begin
                rbuf[rcnt] = rd_data;
                rcnt++;
            end
            fin = (done === 1'b1);
            t++;
            @(posedge clk);
            wr_data <= wbuf[wi % 16];
        end
        chk("done", 8'h01, {7'h00, fin});
        chk("cmd_ready", 8'h01, {7'h00, cmd_ready});
        chk("nack", {7'h00, exp_nack}, {7'h00, nack});
        chk("wr_count", (rd | exp_nack) ? 8'h00 : 8'(n), 8'(wi));
        chk("rd_count", (rd & ~exp_nack) ? 8'(n) : 8'h00, 8'(rcnt));
    endtask : xfer

    task automatic idle();
        int t;
        t = 0;
        while (nv_busy !== 1'b0 && t < 2000)
        begin
            @(negedge clk);
            t++;
        end
        chk("idle", 8'h00, {7'h00, nv_busy});
    endtask : idle

    task automatic wr(input logic [7:0] p, input int n);
        xfer(1'b0, DEV, p, n, 1'b0);
        repeat (8) @(negedge clk);
        chk("nv_busy", 8'h01, {7'h00, nv_busy});
        idle();
    endtask : wr

    task automatic t_page();
        for (int i = 0; i < 16; i++)
            wbuf[i] = 8'hA5 ^ 8'(i);
        wr(8'hA0, 16);
        xfer(1'b1, DEV, 8'hA0, 16, 1'b0);
        chk("rd_count", 8'h10, 8'(rcnt));
        for (int i = 0; i < 16; i++)
            chk("page_byte", 8'hA5 ^ 8'(i), rbuf[i]);
    endtask : t_page

    task automatic t_wrap();
        wbuf[0] = 8'h11;
        wbuf[1] = 8'h22;
        wbuf[2] = 8'h33;
        wr(8'h3E, 3);
        xfer(1'b1, DEV, 8'h3E, 2, 1'b0);
        chk("wrap_3E", 8'h11, rbuf[0]);
        chk("wrap_3F", 8'h22, rbuf[1]);
        xfer(1'b1, DEV, 8'h30, 1, 1'b0);
        chk("wrap_30", 8'h33, rbuf[0]);
    endtask : t_wrap

    task automatic t_regions();
        logic [7:0] pl [4];
        pl = '{8'h9E, 8'hBF, 8'hC0, 8'hFF};
        for (int i = 0; i < 4; i++)
        begin
            wbuf[0] = pl[i] ^ 8'h3C;
            wr(pl[i], 1);
            xfer(1'b1, DEV, pl[i], 1, 1'b0);
            chk("region", pl[i] ^ 8'h3C, rbuf[0]);
        end
    endtask : t_regions

    task automatic t_busy();
        wbuf[0] = 8'h77;
        xfer(1'b0, DEV, 8'h10, 1, 1'b0);
        xfer(1'b1, DEV, 8'h10, 1, 1'b1);
        idle();
        xfer(1'b1, DEV, 8'h10, 1, 1'b0);
        chk("after_busy", 8'h77, rbuf[0]);
    endtask : t_busy

    task automatic t_addr();
        logic [6:0] al [2];
        al = '{7'h00, 7'h7F};
        xfer(1'b1, DEV ^ 7'h01, 8'h10, 1, 1'b1);
        for (int i = 0; i < 2; i++)
        begin
            slave_addr <= al[i];
            xfer(1'b1, al[i], 8'h10, 1, 1'b0);
            chk("any_addr", 8'h77, rbuf[0]);
        end
        slave_addr <= DEV;
    endtask : t_addr

    task automatic t_lock();
        wbuf[0] = 8'h02;
        wr(8'h9F, 1);
        chk("gp_locked", 8'h02, {6'h00, gp_locked});
        wbuf[0] = 8'hEE;
        wr(8'hC0, 1);
        wr(8'hA1, 1);
        xfer(1'b1, DEV, 8'hC0, 2, 1'b0);
        chk("locked_c0", 8'hFC, rbuf[0]);
        chk("next_c1", 8'h00, rbuf[1]);
        xfer(1'b1, DEV, 8'hA1, 1, 1'b0);
        chk("open_a1", 8'hEE, rbuf[0]);
        wbuf[0] = 8'h00;
        wr(8'h9F, 1);
        chk("gp_unlock", 8'h00, {6'h00, gp_locked});
        wbuf[0] = 8'hEE;
        wr(8'hC0, 1);
        xfer(1'b1, DEV, 8'hC0, 1, 1'b0);
        chk("unlocked_c0", 8'hEE, rbuf[0]);
    endtask : t_lock

    task automatic results();
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_read = 1'b0;
        cmd_addr = DEV;
        cmd_ptr = 8'h00;
        cmd_len = 5'h01;
        wr_data = 8'h00;
        slave_addr = DEV;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_page();
        t_wrap();
        t_regions();
        t_busy();
        t_addr();
        t_lock();
        results();
    end

    initial
    begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        results();
    end
endmodule : icma_bench
`default_nettype wire
